// File: rtl/lgx_regs.svh
`ifndef LGX_REGS_SVH
`define LGX_REGS_SVH

// ----------------------------------------------------------------------------
// Opcode groups and addressing modes
// ----------------------------------------------------------------------------
`define LGX_GRP_OR      4'h4
`define LGX_GRP_XOR     4'hb
`define LGX_MODE_RR     4'h2
`define LGX_MODE_RIR    4'h3
`define LGX_MODE_REG    4'h4
`define LGX_MODE_REGIND 4'h5
`define LGX_MODE_IMM    4'h6
`define LGX_MODE_INDIMM 4'h7

// ----------------------------------------------------------------------------
// Operand byte layout and timing
// ----------------------------------------------------------------------------
`define LGX_WREG_PREFIX 4'he
`define LGX_CYC_SHORT   4'h6
`define LGX_CYC_LONG    4'ha
`define LGX_CNT_FIRST   4'h1
`define LGX_BYTE_ZERO   8'h00

`endif

// File: rtl/lgx_pkg.sv
package lgx_pkg;

  // Raw instruction bytes: opcode and up to two operand bytes.
  typedef struct packed {
    logic [7:0] opc;
    logic [7:0] b1;
    logic [7:0] b2;
  } lgx_instr_t;

  // Result of decoding one instruction.
  typedef struct packed {
    logic       valid;
    logic       is_xor;
    logic       src_ind;
    logic       src_imm;
    logic       dst_ind;
    logic [7:0] src_val;
    logic [7:0] dst_addr;
    logic [3:0] cycles;
  } lgx_dec_t;

  // Condition flags of the CPU.
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } lgx_flags_t;

endpackage

// File: rtl/lgx_decode.sv
`timescale 1ns/1ps
`include "lgx_regs.svh"

module lgx_decode
  import lgx_pkg::*;
(
  // Instruction
  input  wire lgx_instr_t instr,
  input  wire logic [7:0] wreg_base,
  // Decode result
  output lgx_dec_t        dec
);

  // --------------------------------------------------------------------------
  // Address helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] wreg_addr(input logic [3:0] idx, input logic [7:0] base);
    wreg_addr = {base[7:4], idx};
  endfunction

  // A full address byte with the working prefix names a working register.
  function automatic logic [7:0] reg_addr(input logic [7:0] b, input logic [7:0] base);
    reg_addr = (b[7:4] == `LGX_WREG_PREFIX) ? wreg_addr(b[3:0], base) : b;
  endfunction

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  wire logic [3:0] grp      = instr.opc[7:4];
  wire logic [3:0] mode     = instr.opc[3:0];
  wire logic       grp_ok   = (grp == `LGX_GRP_OR) || (grp == `LGX_GRP_XOR);
  wire logic       mode_ok  = (mode >= `LGX_MODE_RR) && (mode <= `LGX_MODE_INDIMM);
  wire logic       is_short = (mode == `LGX_MODE_RR) || (mode == `LGX_MODE_RIR);
  wire logic       is_reg   = (mode == `LGX_MODE_REG) || (mode == `LGX_MODE_REGIND);
  wire logic       is_imm   = (mode == `LGX_MODE_IMM) || (mode == `LGX_MODE_INDIMM);

  wire logic [7:0] short_src = wreg_addr(instr.b1[3:0], wreg_base);
  wire logic [7:0] short_dst = wreg_addr(instr.b1[7:4], wreg_base);
  wire logic [7:0] src_val   = is_short ? short_src :
                               is_reg   ? reg_addr(instr.b1, wreg_base) : instr.b2;
  wire logic [7:0] dst_addr  = is_short ? short_dst :
                               is_reg   ? reg_addr(instr.b2, wreg_base) : reg_addr(instr.b1, wreg_base);

  assign dec.valid    = grp_ok && mode_ok;
  assign dec.is_xor   = (grp == `LGX_GRP_XOR);
  assign dec.src_ind  = (mode == `LGX_MODE_RIR) || (mode == `LGX_MODE_REGIND);
  assign dec.src_imm  = is_imm;
  assign dec.dst_ind  = (mode == `LGX_MODE_INDIMM);
  assign dec.src_val  = src_val;
  assign dec.dst_addr = dst_addr;
  assign dec.cycles   = is_short ? `LGX_CYC_SHORT : `LGX_CYC_LONG;

endmodule

// File: rtl/lgx_exec.sv
`timescale 1ns/1ps
`include "lgx_regs.svh"

// Notes on behaviour
// - Exclusive form writes bitwise difference to destination.
// - Source location is never written.
// - Zero flag from result; C, D, H kept.
// - Sign flag is result bit 7; overflow cleared.
// - Address byte Eh-prefix selects a working register.
// - B2/B3: destination high nibble, source low nibble.
// - B4/B5: source byte first, destination byte last.
// - B6: destination byte, then immediate data byte.
// - Opcodes 42-47 are inclusive forms, same layout.
// - Inclusive form writes bitwise OR to destination.
module lgx_exec
  import lgx_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Instruction request
  input  wire logic       instr_valid,
  input  wire lgx_instr_t instr,
  input  wire logic [7:0] wreg_base,
  output logic            instr_ready,
  output logic            illegal,
  output logic            done,
  // Register file port, read data combinational from rf_addr
  output logic [7:0]      rf_addr,
  output logic            rf_wr_en,
  output logic [7:0]      rf_wdata,
  input  wire logic [7:0] rf_rdata,
  // Flags
  output lgx_flags_t      flags_q
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SRC_PTR,
    ST_SRC,
    ST_DST_PTR,
    ST_DST,
    ST_WAIT,
    ST_WB
  } lgx_state_t;

  lgx_state_t  st_q;
  lgx_state_t  st_d;
  lgx_dec_t    dec;
  lgx_dec_t    dec_q;
  logic [7:0]  src_addr_q;
  logic [7:0]  dst_addr_q;
  logic [7:0]  src_q;
  logic [7:0]  res_q;
  logic [3:0]  cnt_q;

  lgx_decode u_decode (
    .instr     (instr),
    .wreg_base (wreg_base),
    .dec       (dec)
  );

  // --------------------------------------------------------------------------
  // Handshake and register file steering
  // --------------------------------------------------------------------------
  wire logic accept    = instr_valid && (st_q == ST_IDLE);
  wire logic src_phase = (st_q == ST_SRC_PTR) || (st_q == ST_SRC);
  wire logic last_wait = (cnt_q >= dec_q.cycles - `LGX_CNT_FIRST);
  // The operation is taken on the freshly read destination so the result is
  // registered on leaving ST_DST, at least two cycles before write-back, and the write data leaves a flop.
  wire logic [7:0] res_d = dec_q.is_xor ? (src_q ^ rf_rdata) : (src_q | rf_rdata);

  assign instr_ready = (st_q == ST_IDLE);
  assign illegal     = accept && !dec.valid;
  assign done        = (st_q == ST_WB);
  assign rf_addr     = src_phase ? src_addr_q : dst_addr_q;
  assign rf_wr_en    = (st_q == ST_WB);
  assign rf_wdata    = res_q;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
        if (accept && dec.valid)
        begin
          if (dec.src_imm)
            st_d = dec.dst_ind ? ST_DST_PTR : ST_DST;
          else
            st_d = dec.src_ind ? ST_SRC_PTR : ST_SRC;
        end
      ST_SRC_PTR: st_d = ST_SRC;
      ST_SRC:     st_d = dec_q.dst_ind ? ST_DST_PTR : ST_DST;
      ST_DST_PTR: st_d = ST_DST;
      ST_DST:     st_d = ST_WAIT;
      ST_WAIT:    st_d = last_wait ? ST_WB : ST_WAIT;
      ST_WB:      st_d = ST_IDLE;
      default:    st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q       <= ST_IDLE;
      dec_q      <= '0;
      src_addr_q <= `LGX_BYTE_ZERO;
      dst_addr_q <= `LGX_BYTE_ZERO;
      src_q      <= `LGX_BYTE_ZERO;
      res_q      <= `LGX_BYTE_ZERO;
      cnt_q      <= '0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= (st_q == ST_IDLE) ? `LGX_CNT_FIRST : cnt_q + `LGX_CNT_FIRST;
      if (accept && dec.valid)
      begin
        dec_q      <= dec;
        src_addr_q <= dec.src_val;
        dst_addr_q <= dec.dst_addr;
        src_q      <= dec.src_val;
      end
      if (st_q == ST_SRC_PTR)
        src_addr_q <= rf_rdata;
      if (st_q == ST_SRC)
        src_q <= rf_rdata;
      if (st_q == ST_DST_PTR)
        dst_addr_q <= rf_rdata;
      if (st_q == ST_DST)
        res_q <= res_d;
    end
  end

  // --------------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      flags_q <= '0;
    else if (st_q == ST_WB)
    begin
      flags_q.z <= (res_q == `LGX_BYTE_ZERO);
      flags_q.s <= res_q[7];
      flags_q.v <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [7:0] dst_val_q;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      dst_val_q <= `LGX_BYTE_ZERO;
    else if (st_q == ST_DST)
      dst_val_q <= rf_rdata;
  end

  xor_result_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done && dec_q.is_xor |-> rf_wdata == (src_q ^ dst_val_q))
    else $error("Exclusive result does not match operands.");

  or_result_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done && !dec_q.is_xor |-> rf_wdata == (src_q | dst_val_q))
    else $error("Inclusive result does not match operands.");

  single_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rf_wr_en |-> rf_addr == dst_addr_q ##1 !rf_wr_en)
    else $error("Write went to a location other than the destination.");

  zero_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done |=> flags_q.z == ($past(rf_wdata) == 8'h00) && $stable(flags_q.c) && $stable(flags_q.d)
             && $stable(flags_q.h))
    else $error("Zero flag wrong or other flags disturbed.");

  sign_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done |=> flags_q.s == $past(rf_wdata[7]) && !flags_q.v)
    else $error("Sign or overflow flag wrong.");

  wreg_map_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    accept && instr.opc == 8'hb4 && instr.b1[7:4] == 4'he
    |=> src_addr_q == {$past(wreg_base[7:4]), $past(instr.b1[3:0])})
    else $error("Working register prefix not mapped.");

  short_layout_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    accept && instr.opc == 8'hb2 |=> dst_addr_q == {$past(wreg_base[7:4]), $past(instr.b1[7:4])})
    else $error("Short form destination nibble wrong.");

  reg_order_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    accept && instr.opc == 8'hb4 && instr.b2[7:4] != 4'he |=> dst_addr_q == $past(instr.b2))
    else $error("Register form destination byte wrong.");

  imm_layout_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    accept && instr.opc == 8'hb6 |=> src_q == $past(instr.b2) && dec_q.is_xor)
    else $error("Immediate byte not taken from third byte.");

  or_decode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    accept && instr.opc == 8'h44 |=> dec_q.valid && !dec_q.is_xor)
    else $error("Inclusive opcode decoded wrongly.");

  short_time_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    accept && dec.valid && dec.cycles == 4'h6 |-> !done [*6] ##1 done)
    else $error("Short form did not finish in six cycles.");

  long_time_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    accept && dec.valid && dec.cycles == 4'ha |-> !done [*5] ##1 !done [*5] ##1 done)
    else $error("Long form did not finish in ten cycles.");

  ptr_follow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q == ST_SRC_PTR |=> st_q == ST_SRC && rf_addr == $past(rf_rdata))
    else $error("Indirect source not fetched through pointer.");

endmodule

// File: tb/lgx_exec_tb.sv
`timescale 1ns/1ps

module lgx_exec_tb
  import lgx_pkg::*;
;
  typedef struct packed {
    lgx_instr_t ins;
    logic [7:0] base;
    logic [7:0] a0, v0, a1, v1, a2, v2;
    logic [7:0] dst;
    logic [7:0] res;
    logic [3:0] cyc;
  } lgx_row_t;

  // ----------------------------------------------------------------------------
  // Design, clock and register file
  // ----------------------------------------------------------------------------
  logic       clk_sys     = 1'b0;
  logic       sys_rst     = 1'b1;
  logic       instr_valid = 1'b0;
  lgx_instr_t instr       = '0;
  logic [7:0] wreg_base   = 8'h00;
  logic [7:0] rf_rdata;
  logic       instr_ready, illegal, done, rf_wr_en;
  logic [7:0] rf_addr, rf_wdata;
  lgx_flags_t flags_q;
  logic [7:0] mem [256];
  int         bad_count   = 0;
  int         checked     = 0;
  int         wr_count    = 0;
  int         cyc_count   = 0;
  lgx_row_t   rows [15];

  always #5 clk_sys = ~clk_sys;

  // The register file answers combinationally, as the design expects.
  assign rf_rdata = mem[rf_addr];

  always @(posedge clk_sys)
  begin
    cyc_count++;
    if (rf_wr_en === 1'b1)
    begin
      mem[rf_addr] <= rf_wdata;
      wr_count++;
    end
    if (cyc_count == 3000)
    begin
      bad_count++;
      end_sim();
    end
  end

  lgx_exec lgx_exec_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
    .wreg_base(wreg_base), .instr_ready(instr_ready), .illegal(illegal), .done(done),
    .rf_addr(rf_addr), .rf_wr_en(rf_wr_en), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata),
    .flags_q(flags_q)
  );

  // ----------------------------------------------------------------------------
  // Checking and sequencing tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic run_row(input lgx_row_t r);
    int         cyc;
    lgx_flags_t fx;
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0] ^ 8'ha5;
    mem[r.a0] = r.v0;
    mem[r.a1] = r.v1;
    mem[r.a2] = r.v2;
    wr_count = 0;
    instr = r.ins;
    wreg_base = r.base;
    instr_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    instr_valid = 1'b0;
    cyc = 1;
    chk({7'h00, instr_ready}, 8'h00);
    while (done !== 1'b1 && cyc < 16)
    begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end
    chk(cyc[7:0], {4'h0, r.cyc});
    chk(rf_addr, r.dst);
    chk(rf_wdata, r.res);
    @(posedge clk_sys);
    #1;
    fx = {1'b0, r.res == 8'h00, r.res[7], 3'b000};
    chk({2'b00, flags_q}, {2'b00, fx});
    chk(mem[r.dst], r.res);
    chk(wr_count[7:0], 8'h01);
    chk({7'h00, instr_ready}, 8'h01);
    if (r.a0 != r.dst) chk(mem[r.a0], r.v0);
    if (r.a1 != r.dst) chk(mem[r.a1], r.v1);
    if (r.a2 != r.dst) chk(mem[r.a2], r.v2);
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    rows = '{
      '{24'hb21e00, 8'h20, 8'h21, 8'h34, 8'h2e, 8'h4d, 8'h2e, 8'h4d, 8'h21, 8'h79, 4'h6},
      '{24'h421e00, 8'h20, 8'h21, 8'h34, 8'h2e, 8'h4d, 8'h2e, 8'h4d, 8'h21, 8'h7d, 4'h6},
      '{24'hb21e00, 8'h70, 8'h71, 8'h34, 8'h7e, 8'h4d, 8'h7e, 8'h4d, 8'h71, 8'h79, 4'h6},
      '{24'hb34d00, 8'h20, 8'h24, 8'hf9, 8'h2d, 8'h7b, 8'h7b, 8'h6a, 8'h24, 8'h93, 4'h6},
      '{24'h434d00, 8'h20, 8'h24, 8'hf9, 8'h2d, 8'h7b, 8'h7b, 8'h6a, 8'h24, 8'hfb, 4'h6},
      '{24'hb4423a, 8'h20, 8'h3a, 8'hf5, 8'h42, 8'h1b, 8'h42, 8'h1b, 8'h3a, 8'hee, 4'ha},
      '{24'h44423a, 8'h20, 8'h3a, 8'hf5, 8'h42, 8'h1b, 8'h42, 8'h1b, 8'h3a, 8'hff, 4'ha},
      '{24'hb4e13a, 8'h20, 8'h3a, 8'hf0, 8'h21, 8'h0f, 8'h21, 8'h0f, 8'h3a, 8'hff, 4'ha},
      '{24'hb545e5, 8'h20, 8'h25, 8'hf0, 8'h45, 8'h3a, 8'h3a, 8'h7f, 8'h25, 8'h8f, 4'ha},
      '{24'h4545e5, 8'h20, 8'h25, 8'h70, 8'h45, 8'h3a, 8'h3a, 8'h7f, 8'h25, 8'h7f, 4'ha},
      '{24'hb67af0, 8'h20, 8'h7a, 8'hf7, 8'h7a, 8'hf7, 8'h7a, 8'hf7, 8'h7a, 8'h07, 4'ha},
      '{24'h467af0, 8'h20, 8'h7a, 8'hf3, 8'h7a, 8'hf3, 8'h7a, 8'hf3, 8'h7a, 8'hf3, 4'ha},
      '{24'hb67af0, 8'h20, 8'h7a, 8'hf0, 8'h7a, 8'hf0, 8'h7a, 8'hf0, 8'h7a, 8'h00, 4'ha},
      '{24'hb7e305, 8'h20, 8'h23, 8'h3e, 8'h3e, 8'h6c, 8'h3e, 8'h6c, 8'h3e, 8'h69, 4'ha},
      '{24'h47e305, 8'h20, 8'h23, 8'h3e, 8'h3e, 8'h0c, 8'h3e, 8'h0c, 8'h3e, 8'h0d, 4'ha}
    };
    @(posedge clk_sys);
    #1;
    chk({instr_ready, done, rf_wr_en, 5'h00}, 8'h80);
    chk({2'b00, flags_q}, 8'h00);
    @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    foreach (rows[i])
      run_row(rows[i]);
    // An opcode from the unused format table must be refused without a write.
    wr_count = 0;
    instr = 24'h821e00;
    instr_valid = 1'b1;
    #1;
    chk({7'h00, illegal}, 8'h01);
    @(posedge clk_sys);
    #1;
    instr_valid = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    chk(wr_count[7:0], 8'h00);
    // A reset in mid-instruction must abandon the write-back.
    instr = 24'hb67af0;
    instr_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    instr_valid = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    sys_rst = 1'b1;
    #1;
    chk({instr_ready, done, rf_wr_en, 5'h00}, 8'h80);
    @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    chk(wr_count[7:0], 8'h00);
    run_row(rows[0]);
    end_sim();
  end
endmodule
